// ==== src/tfs_sequencer.sv ====
// four-slot control sequencer with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module tfs_sequencer
   import tfs_pkg::*;
#(
   parameter int TICKS_PER_SEC = TFS_CLK_HZ,
   parameter int PULSE_CYCLES = TFS_PULSE_CYC,
   parameter int FAST_CYCLES = TFS_FLASH_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] station_pass_request,
   output logic [3:0] station_grant,
   output logic [3:0] station_display,
   output logic panel_indicator
);
   // register state
   logic start_ff, nxt_start;
   logic hold_mode_ff, nxt_hold_mode;
   logic timer_on_ff, nxt_timer_on;
   logic [6:0] secs_ff, nxt_secs;
   logic [11:0] sel_ff, nxt_sel;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [31:0] wmask;
   logic [31:0] ctrl_w;
   logic [31:0] secs_w;
   logic [31:0] sel_w;
   logic wr_go;
   logic rd_go;
   // sequencing state
   logic [3:0] trig_ff, nxt_trig;
   logic [3:0] hold_ff, nxt_hold;
   logic gate_ff, nxt_gate;
   logic trip_ff, nxt_trip;
   logic raw_d_ff, nxt_raw_d;
   logic ext_ff, nxt_ext;
   logic flash_ff, nxt_flash;
   logic [3:0] pass_d_ff;
   logic [3:0] grant_ff, nxt_grant;
   logic [3:0] disp_ff, nxt_disp;
   logic panel_ff, nxt_panel;
   logic raw_pulse;
   logic gated;
   logic clip_pass;
   logic [3:0] owner;
   logic [3:0] skip_mask;
   logic skip_now;
   logic pass_now;
   logic step;
   logic [3:0] leave;

   tfs_interval_timer #(
      .TICKS_PER_SEC(TICKS_PER_SEC),
      .PULSE_CYCLES(PULSE_CYCLES),
      .FAST_CYCLES(FAST_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .run(timer_on_ff),
      .fast(ext_ff),
      .interval_seconds_knob(secs_ff),
      .pulse(raw_pulse)
   );

   // bus handshakes: write address and data are taken together
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign rd_go = s_axi_arvalid && !rvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   // byte lanes merge into the old register value
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{s_axi_wstrb[b]}};
      end
      ctrl_w = ({29'h0, timer_on_ff, hold_mode_ff, 1'b0} & ~wmask) | (s_axi_wdata & wmask);
      secs_w = ({25'h0, secs_ff} & ~wmask) | (s_axi_wdata & wmask);
      sel_w = ({20'h0, sel_ff} & ~wmask) | (s_axi_wdata & wmask);
   end

   // register writes and answers; start bit is a one-cycle strobe
   always_comb begin
      nxt_start = 1'b0;
      nxt_hold_mode = hold_mode_ff;
      nxt_timer_on = timer_on_ff;
      nxt_secs = secs_ff;
      nxt_sel = sel_ff;
      nxt_bvalid = bvalid_ff && !s_axi_bready;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff && !s_axi_rready;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      if (wr_go) begin
         nxt_bvalid = 1'b1;
         nxt_bresp = TFS_RESP_OKAY;
         case (s_axi_awaddr)
            TFS_OFS_CTRL: begin
               nxt_start = ctrl_w[TFS_CTRL_START_BIT];
               nxt_hold_mode = ctrl_w[TFS_CTRL_HOLD_BIT];
               nxt_timer_on = ctrl_w[TFS_CTRL_TIMER_BIT];
            end
            TFS_OFS_INTERVAL: nxt_secs = secs_w[6:0];
            TFS_OFS_SELECT: nxt_sel = sel_w[11:0];
            TFS_OFS_STATUS: nxt_bresp = TFS_RESP_OKAY;
            default: nxt_bresp = TFS_RESP_SLVERR;
         endcase
      end
      if (rd_go) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = TFS_RESP_OKAY;
         case (s_axi_araddr)
            TFS_OFS_CTRL: nxt_rdata = {29'h0, timer_on_ff, hold_mode_ff, 1'b0};
            TFS_OFS_INTERVAL: nxt_rdata = {25'h0, secs_ff};
            TFS_OFS_SELECT: nxt_rdata = {20'h0, sel_ff};
            TFS_OFS_STATUS: nxt_rdata = {16'h0, raw_pulse, flash_ff, gate_ff, ext_ff,
                                          owner, hold_ff, trig_ff};
            default: begin
               nxt_rdata = 32'h0;
               nxt_rresp = TFS_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         start_ff <= 1'b0;
         hold_mode_ff <= 1'b0;
         timer_on_ff <= 1'b0;
         secs_ff <= TFS_SECS_RST;
         sel_ff <= TFS_SELECT_RST;
         bvalid_ff <= 1'b0;
         bresp_ff <= TFS_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= TFS_RESP_OKAY;
         rdata_ff <= 32'h0;
      end else begin
         start_ff <= nxt_start;
         hold_mode_ff <= nxt_hold_mode;
         timer_on_ff <= nxt_timer_on;
         secs_ff <= nxt_secs;
         sel_ff <= nxt_sel;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   // gate, clipping and skip/pass decisions
   always_comb begin
      gated = raw_pulse && gate_ff;
      clip_pass = gated && !trip_ff;
      owner = trig_ff & hold_ff;
      for (int i = 0; i < 4; i++) begin
         skip_mask[i] = (sel_ff[i*TFS_SEL_W +: TFS_SEL_W] > 3'h3);
      end
      skip_now = |(owner & skip_mask);
      pass_now = |(grant_ff & station_pass_request & ~pass_d_ff);
      step = clip_pass || skip_now || pass_now;
      leave = step ? hold_ff : 4'h0;
   end

   // ring, gate, trip and extended control next state
   always_comb begin
      // a new trigger gets its hold one cycle later, after the clipped pulse
      nxt_trig = (trig_ff & ~leave) | (step ? {hold_ff[2:0], hold_ff[3]} : 4'h0);
      nxt_hold = (hold_ff & ~leave) | (trig_ff & ~leave);
      if (start_ff) begin
         nxt_trig = 4'h1;
         nxt_hold = 4'h1;
      end
      // gate stays in for a pulse already under way when hold mode is chosen
      nxt_gate = !hold_mode_ff || (gate_ff && raw_pulse);
      nxt_trip = gated;
      nxt_raw_d = raw_pulse;
      nxt_ext = ext_ff;
      if (!hold_mode_ff || skip_now || pass_now || start_ff) begin
         nxt_ext = 1'b0;
      end else if (raw_pulse && !raw_d_ff && !gate_ff && |owner) begin
         nxt_ext = 1'b1;
      end
      nxt_flash = ext_ff ? (flash_ff ^ (raw_pulse && !raw_d_ff)) : 1'b1;
   end

   // station routing; indicator blanks on the dark flash phase
   always_comb begin
      nxt_grant = 4'h0;
      nxt_disp = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (owner[i] && !skip_mask[i]) begin
            nxt_grant[sel_ff[i*TFS_SEL_W +: 2]] = 1'b1;
            nxt_disp[sel_ff[i*TFS_SEL_W +: 2]] = flash_ff;
         end
      end
      nxt_panel = |nxt_disp;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trig_ff <= 4'h0;
         hold_ff <= 4'h0;
         gate_ff <= 1'b1;
         trip_ff <= 1'b0;
         raw_d_ff <= 1'b0;
         ext_ff <= 1'b0;
         flash_ff <= 1'b1;
         pass_d_ff <= 4'h0;
         grant_ff <= 4'h0;
         disp_ff <= 4'h0;
         panel_ff <= 1'b0;
      end else begin
         trig_ff <= nxt_trig;
         hold_ff <= nxt_hold;
         gate_ff <= nxt_gate;
         trip_ff <= nxt_trip;
         raw_d_ff <= nxt_raw_d;
         ext_ff <= nxt_ext;
         flash_ff <= nxt_flash;
         pass_d_ff <= station_pass_request;
         grant_ff <= nxt_grant;
         disp_ff <= nxt_disp;
         panel_ff <= nxt_panel;
      end
   end

   assign station_grant = grant_ff;
   assign station_display = disp_ff;
   assign panel_indicator = panel_ff;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_clip_one_cycle: assert property (clip_pass |=> !clip_pass)
      else $error("clipped pulse longer than one cycle");
   a_trip_cuts_pass: assert property (gated ##1 gated |-> !clip_pass)
      else $error("trip stage failed to cut the pulse");
   a_gate_blocks: assert property (!gate_ff |-> !clip_pass)
      else $error("pulse passed while gate off");
   a_one_owner: assert property ($onehot0(owner))
      else $error("more than one slot owns control");
   a_start_slot1: assert property (start_ff |=> trig_ff == 4'h1 && hold_ff == 4'h1)
      else $error("start did not give slot one control");
   a_step_moves: assert property (clip_pass && owner == 4'h8 && !start_ff
      |=> trig_ff == 4'h1 && hold_ff == 4'h0 ##1 owner == 4'h1)
      else $error("slot four did not wrap to slot one");
   a_skip_leaves: assert property (skip_now && !start_ff |=> owner == 4'h0)
      else $error("skipped slot kept control");
   // selector taken from the cycle of the owner, as a write may change it meanwhile
   a_grant_follows: assert property (owner[0] && !skip_mask[0] && !start_ff && !step
      |=> grant_ff[$past(sel_ff[1:0])])
      else $error("owner grant missing");
   a_no_ext_in_auto: assert property (!hold_mode_ff |=> !ext_ff)
      else $error("extended control outside hold mode");
   a_dark_phase: assert property (!flash_ff |=> disp_ff == 4'h0)
      else $error("display lit in dark flash phase");
   c_advance: cover property (clip_pass && |owner);
   c_skip: cover property (skip_now);
   c_extended: cover property ($rose(ext_ff));
   c_pass: cover property (pass_now && ext_ff);
endmodule : tfs_sequencer
`default_nettype wire

// ==== src/tfs_pkg.sv ====
// constants shared by the timed four-slot control sequencer
//
// Overview of operation
// - advance pulse repeats at an interval of 20 to 90 seconds
// - each advance pulse lasts a fraction of a second
// - advance pulses reach the ring only while the normal-mode gate is on
// - four slots, each a trigger and hold stage; both set means control
// - a slot triggers only if the previous hold is set; previous then clears
// - owning slot drives grant and indicator until the next advance
// - start sets slot one; later pulses move control onward
// - ring keeps advancing whatever the single-station selector says
// - start during another slot clears it and hands control to slot one
// - start leaves the interval timer running untouched
// - delivered pulse ends before the new slot's hold stage sets
// - a trip stage set by the pulse cuts off the passed pulse
// - selector routes a slot grant to a station or to the skip handler
// - selector routes the indicator to that station, none when skipped
// - any station order, each slot skippable on its own
// - hold mode keeps the station in control until pass or skip
// - lit indicators flash during extended control
// - slot four hands control to slot one
// - a skipped slot hands control onward at once
// - gate off withholds pulses; no automatic change
package tfs_pkg;
   // register byte offsets
   localparam logic [3:0] TFS_OFS_CTRL = 4'h0;
   localparam logic [3:0] TFS_OFS_INTERVAL = 4'h4;
   localparam logic [3:0] TFS_OFS_SELECT = 4'h8;
   localparam logic [3:0] TFS_OFS_STATUS = 4'hc;
   // control fields
   localparam int TFS_CTRL_START_BIT = 0;
   localparam int TFS_CTRL_HOLD_BIT = 1;
   localparam int TFS_CTRL_TIMER_BIT = 2;
   // selector: 3 bits per slot, codes 0..3 a station, 4 skip
   localparam int TFS_SEL_W = 3;
   localparam logic [2:0] TFS_SEL_SKIP = 3'h4;
   localparam logic [11:0] TFS_SELECT_RST = 12'h688;
   // interval limits and reset value in seconds
   localparam logic [6:0] TFS_SECS_MIN = 7'h14;
   localparam logic [6:0] TFS_SECS_MAX = 7'h5a;
   localparam logic [6:0] TFS_SECS_RST = 7'h32;
   // timing
   localparam int TFS_CLK_HZ = 20_000_000;
   localparam int TFS_PULSE_MS = 100;
   localparam int TFS_FLASH_MS = 500;
   localparam int TFS_PULSE_CYC = TFS_PULSE_MS * (TFS_CLK_HZ / 1000);
   localparam int TFS_FLASH_CYC = TFS_FLASH_MS * (TFS_CLK_HZ / 1000);
   localparam logic [1:0] TFS_RESP_OKAY = 2'h0;
   localparam logic [1:0] TFS_RESP_SLVERR = 2'h2;
endpackage : tfs_pkg

// ==== src/tfs_interval_timer.sv ====
// free-running interval pulse source with a fast rate for flashing
`timescale 1ns/1ps
`default_nettype none
module tfs_interval_timer
   import tfs_pkg::*;
#(
   parameter int TICKS_PER_SEC = TFS_CLK_HZ,
   parameter int PULSE_CYCLES = TFS_PULSE_CYC,
   parameter int FAST_CYCLES = TFS_FLASH_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic fast,
   input wire logic [6:0] interval_seconds_knob,
   output logic pulse
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic [31:0] period;
   logic [6:0] secs;
   logic pulse_ff;
   logic nxt_pulse;
   logic [31:0] high_cnt_ff;
   logic [31:0] nxt_high_cnt;

   // clamp the setting, then period in ticks
   always_comb begin
      secs = interval_seconds_knob;
      if (secs < TFS_SECS_MIN) begin
         secs = TFS_SECS_MIN;
      end else if (secs > TFS_SECS_MAX) begin
         secs = TFS_SECS_MAX;
      end
      period = fast ? 32'(FAST_CYCLES) : 32'(secs) * 32'(TICKS_PER_SEC);
   end

   // start input never reaches this counter, so restarts keep the schedule
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_pulse = 1'b0;
      if (run) begin
         nxt_cnt = (cnt_ff + 32'h1 >= period) ? 32'h0 : cnt_ff + 32'h1;
         nxt_pulse = (nxt_cnt < 32'(PULSE_CYCLES));
      end
   end

   // cycles the pulse has stood so far; a long pulse would be too long to count by repetition
   always_comb begin
      nxt_high_cnt = pulse_ff ? high_cnt_ff + 32'h1 : 32'h0;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_ff <= 32'h0;
         pulse_ff <= 1'b0;
         high_cnt_ff <= 32'h0;
      end else begin
         cnt_ff <= nxt_cnt;
         pulse_ff <= nxt_pulse;
         high_cnt_ff <= nxt_high_cnt;
      end
   end

   assign pulse = pulse_ff;

   a_pulse_short: assert property (@(posedge ref_clk) disable iff (rst)
      pulse_ff |-> high_cnt_ff < 32'(PULSE_CYCLES))
      else $error("advance pulse lasted too long");
endmodule : tfs_interval_timer
`default_nettype wire

// ==== verification/tfs_station_model.sv ====
// operator station model that requests a pass while it holds control
`timescale 1ns/1ps
`default_nettype none
module tfs_station_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] pass_cmd,
   input wire logic [3:0] station_grant,
   output logic [3:0] station_pass_request
);
   // an operator only passes while in control, and lets go once control leaves
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         station_pass_request <= 4'h0;
      end else begin
         station_pass_request <= pass_cmd & station_grant;
      end
   end
endmodule : tfs_station_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the four-slot control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tfs_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [3:0] pass_cmd = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd_data;
   logic [3:0] station_pass_request, station_grant, station_display;
   logic panel_indicator;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int n, bad, saw_off, saw_on;

   // 50 ns period
   always #25 ref_clk = ~ref_clk;

   // short counts keep the run small: one second is 100 cycles
   tfs_sequencer #(.TICKS_PER_SEC(100), .PULSE_CYCLES(5), .FAST_CYCLES(40)) DUT (
      .ref_clk(ref_clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .station_pass_request(station_pass_request), .station_grant(station_grant),
      .station_display(station_display), .panel_indicator(panel_indicator)
   );

   tfs_station_model stations (
      .ref_clk(ref_clk), .rst(rst), .pass_cmd(pass_cmd),
      .station_grant(station_grant), .station_pass_request(station_pass_request)
   );

   task end_sim;
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // ready is sampled at the falling edge; inputs only move after rising edges
   task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa, pw, ra, rw, bv;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge ref_clk);
         ra = s_axi_awready;
         rw = s_axi_wready;
         @(posedge ref_clk);
         if (pa && ra) begin
            s_axi_awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && rw) begin
            s_axi_wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      bv = 1'b0;
      while (!bv) begin
         @(negedge ref_clk);
         bv = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge ref_clk);
      end
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic pa, rv;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      pa = 1'b0;
      while (!pa) begin
         @(negedge ref_clk);
         pa = s_axi_arready;
         @(posedge ref_clk);
      end
      s_axi_arvalid <= 1'b0;
      rv = 1'b0;
      while (!rv) begin
         @(negedge ref_clk);
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge ref_clk);
      end
      s_axi_rready <= 1'b0;
   endtask : rd

   // waits for a grant pattern under a bound and returns the cycles spent
   task wait_grant(input logic [3:0] e, input int lim, output int cnt);
      cnt = 0;
      @(negedge ref_clk);
      while (station_grant !== e && cnt < lim) begin
         @(negedge ref_clk);
         cnt++;
      end
      chk({28'h0, station_grant}, {28'h0, e});
   endtask : wait_grant

   // hang guard: the sequence needs about 16000 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors++;
         end_sim();
      end
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      // look at the outputs once they have settled
      @(negedge ref_clk);
      // reset values and bus errors
      chk({28'h0, station_grant}, 32'h0);
      chk({31'h0, panel_indicator}, 32'h0);
      rd(TFS_OFS_CTRL, rd_data, resp);
      chk(rd_data, 32'h0);
      rd(TFS_OFS_INTERVAL, rd_data, resp);
      chk(rd_data, 32'h32);
      rd(TFS_OFS_SELECT, rd_data, resp);
      chk(rd_data, 32'h688);
      // no stage set; normal gate and lit flash phase are the idle levels
      rd(TFS_OFS_STATUS, rd_data, resp);
      chk(rd_data, 32'h6000);
      rd(4'h2, rd_data, resp);
      chk({30'h0, resp}, {30'h0, TFS_RESP_SLVERR});
      wr(4'h6, 32'h1, resp);
      chk({30'h0, resp}, {30'h0, TFS_RESP_SLVERR});
      // a write with no byte lane enabled leaves the register alone
      s_axi_wstrb <= 4'h0;
      wr(TFS_OFS_INTERVAL, 32'h7f, resp);
      s_axi_wstrb <= 4'hf;
      rd(TFS_OFS_INTERVAL, rd_data, resp);
      chk(rd_data, 32'h32);
      $display("test reset done");
      // timer alone grants nothing; start hands control to slot one
      wr(TFS_OFS_INTERVAL, 32'h14, resp);
      wr(TFS_OFS_CTRL, 32'h4, resp);
      repeat (30) @(posedge ref_clk);
      chk({28'h0, station_grant}, 32'h0);
      wr(TFS_OFS_CTRL, 32'h5, resp);
      wait_grant(4'h1, 10, n);
      chk({28'h0, station_display}, 32'h1);
      chk({31'h0, panel_indicator}, 32'h1);
      rd(TFS_OFS_STATUS, rd_data, resp);
      chk({28'h0, rd_data[11:8]}, 32'h1);
      wait_grant(4'h2, 2100, n);
      wait_grant(4'h4, 2100, n);
      chk(32'(n >= 1995 && n <= 2005), 32'h1);
      $display("test start and advance done");
      // restart in slot three; the timer keeps its own schedule
      repeat (500) @(posedge ref_clk);
      wr(TFS_OFS_CTRL, 32'h5, resp);
      wait_grant(4'h1, 10, n);
      wait_grant(4'h2, 1600, n);
      chk(32'(n > 1400), 32'h1);
      $display("test restart done");
      // slot1 st3, slot2 skip, slot3 st0, slot4 st1
      wr(TFS_OFS_SELECT, 32'h223, resp);
      wait_grant(4'h1, 10, n);
      chk({28'h0, station_display}, 32'h1);
      wait_grant(4'h2, 2100, n);
      wait_grant(4'h8, 2100, n);
      wait_grant(4'h1, 2100, n);
      $display("test selectors done");
      // pass from the station in control
      @(posedge ref_clk);
      pass_cmd <= 4'h1;
      wait_grant(4'h2, 10, n);
      @(posedge ref_clk);
      pass_cmd <= 4'h0;
      // hold mode: no advance, indicators flash
      wr(TFS_OFS_CTRL, 32'h6, resp);
      bad = 0;
      saw_off = 0;
      saw_on = 0;
      repeat (2100) begin
         @(negedge ref_clk);
         if (station_grant !== 4'h2) bad++;
         if (station_display === 4'h0) saw_off = 1;
         if (station_display === 4'h2) saw_on = 1;
      end
      chk(bad, 32'h0);
      chk(32'(saw_off + saw_on), 32'h2);
      @(posedge ref_clk);
      pass_cmd <= 4'h2;
      wait_grant(4'h8, 10, n);
      @(posedge ref_clk);
      pass_cmd <= 4'h0;
      wr(TFS_OFS_CTRL, 32'h4, resp);
      wait_grant(4'h1, 4100, n);
      $display("test hold and pass done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
